// *** ipsel_pkg.sv ***
package ipsel_pkg;
  localparam logic [7:0] IPSEL_PRIO_ADDR  = 8'hb8;
  localparam logic [7:0] IPSEL_PRIO_RESET = 8'hc0;
  localparam logic [7:0] IPSEL_USED_MASK  = 8'h3f;
  localparam logic [7:0] IPSEL_FILL_ONES  = 8'hc0;
  localparam int IPSEL_BIT_T2  = 5;
  localparam int IPSEL_BIT_S0  = 4;
  localparam int IPSEL_BIT_T1  = 3;
  localparam int IPSEL_BIT_X1  = 2;
  localparam int IPSEL_BIT_T0  = 1;
  localparam int IPSEL_BIT_X0  = 0;
  localparam int IPSEL_NSRC    = 6;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ipsel_sfr_req_s;

  typedef struct packed {
    logic [5:0] hi;
    logic [5:0] lo;
  } ipsel_prio_req_s;
endpackage

// *** ipsel_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipsel_top (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_sys_rst,
  input  wire ipsel_pkg::ipsel_sfr_req_s i_sfr,
  input  wire logic [5:0]               i_irq_pend,
  output logic      [7:0]               o_sfr_rdata,
  output logic                          o_sfr_hit,
  output logic                          o_timer2_priority_bit,
  output logic                          o_serial0_priority_bit,
  output logic                          o_timer1_priority_bit,
  output logic                          o_ext_irq1_priority_bit,
  output logic                          o_timer0_priority_bit,
  output logic                          o_ext_irq0_priority_bit,
  output ipsel_pkg::ipsel_prio_req_s    o_prio_req,
  output logic                          o_hi_pending
);
  import ipsel_pkg::*;

  logic [7:0] interrupt_priority_levels_q;
  logic       hit_w;
  logic       hit_q;

  function automatic logic addr_match(input logic [7:0] a);
    addr_match = (a == IPSEL_PRIO_ADDR);
  endfunction

  assign hit_w = addr_match(i_sfr.addr);

  // only the low six bits are stored; top bits forced to one
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      interrupt_priority_levels_q <= IPSEL_PRIO_RESET;
    end else if (i_sfr.wr && hit_w) begin
      interrupt_priority_levels_q <= (i_sfr.wdata & IPSEL_USED_MASK) | IPSEL_FILL_ONES;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_sfr_rdata <= 8'h00;
      hit_q       <= 1'b0;
    end else begin
      hit_q <= i_sfr.rd && hit_w;
      if (i_sfr.rd && hit_w) begin
        o_sfr_rdata <= interrupt_priority_levels_q | IPSEL_FILL_ONES;
      end
    end
  end

  assign o_sfr_hit = hit_q;

  assign o_timer2_priority_bit   = interrupt_priority_levels_q[IPSEL_BIT_T2];
  assign o_serial0_priority_bit  = interrupt_priority_levels_q[IPSEL_BIT_S0];
  assign o_timer1_priority_bit   = interrupt_priority_levels_q[IPSEL_BIT_T1];
  assign o_ext_irq1_priority_bit = interrupt_priority_levels_q[IPSEL_BIT_X1];
  assign o_timer0_priority_bit   = interrupt_priority_levels_q[IPSEL_BIT_T0];
  assign o_ext_irq0_priority_bit = interrupt_priority_levels_q[IPSEL_BIT_X0];

  // combinational split so the core sees a level change in the same cycle
  always_comb begin
    o_prio_req.hi = i_irq_pend & interrupt_priority_levels_q[5:0];
    o_prio_req.lo = i_irq_pend & ~interrupt_priority_levels_q[5:0];
  end
  assign o_hi_pending = |o_prio_req.hi;

  // checker decode kept apart from addr_match so a broken decoder is caught
  logic ast_wr_sel;
  logic ast_rd_sel;

  assign ast_wr_sel = i_sfr.wr && (i_sfr.addr == IPSEL_PRIO_ADDR);
  assign ast_rd_sel = i_sfr.rd && (i_sfr.addr == IPSEL_PRIO_ADDR);

  AST_TOP_ONES: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    interrupt_priority_levels_q[7:6] == 2'b11)
    else $error("top bits not one");

  AST_RD_ONES: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_sfr_hit |-> o_sfr_rdata[7:6] == 2'b11)
    else $error("read top bits not one");

  AST_RESET_VAL: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $past(i_sys_rst) |-> (interrupt_priority_levels_q == IPSEL_PRIO_RESET) && !o_sfr_hit)
    else $error("register not at reset value after reset");

  AST_HIT_RD: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_rd_sel |=> o_sfr_hit)
    else $error("read of register gave no hit");

  AST_NO_HIT: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !ast_rd_sel |=> !o_sfr_hit)
    else $error("hit without a read of the register");

  AST_RD_STAND: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !ast_rd_sel |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");

  AST_RD_OLD: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (ast_wr_sel && ast_rd_sel) |=> o_sfr_rdata[5:0] == $past(interrupt_priority_levels_q[5:0]))
    else $error("read with write did not return old value");

  AST_WR_OTHER: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (i_sfr.wr && (i_sfr.addr != IPSEL_PRIO_ADDR)) |=> $stable(interrupt_priority_levels_q))
    else $error("write to other address changed register");

  AST_WR_T2: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_wr_sel |=> o_timer2_priority_bit == $past(i_sfr.wdata[IPSEL_BIT_T2]))
    else $error("timer2 bit not written");

  AST_WR_S0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_wr_sel |=> o_serial0_priority_bit == $past(i_sfr.wdata[IPSEL_BIT_S0]))
    else $error("serial0 bit not written");

  AST_WR_T1: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_wr_sel |=> o_timer1_priority_bit == $past(i_sfr.wdata[IPSEL_BIT_T1]))
    else $error("timer1 bit not written");

  AST_WR_X1: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_wr_sel |=> o_ext_irq1_priority_bit == $past(i_sfr.wdata[IPSEL_BIT_X1]))
    else $error("ext1 bit not written");

  AST_WR_T0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_wr_sel |=> o_timer0_priority_bit == $past(i_sfr.wdata[IPSEL_BIT_T0]))
    else $error("timer0 bit not written");

  AST_WR_X0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_wr_sel |=> o_ext_irq0_priority_bit == $past(i_sfr.wdata[IPSEL_BIT_X0]))
    else $error("ext0 bit not written");

  AST_HOLD: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !ast_wr_sel |=> $stable(interrupt_priority_levels_q))
    else $error("register changed without write");

  AST_RD_T2: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_rd_sel |=> o_sfr_rdata[IPSEL_BIT_T2] == $past(o_timer2_priority_bit))
    else $error("timer2 bit not read back");

  AST_RD_S0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_rd_sel |=> o_sfr_rdata[IPSEL_BIT_S0] == $past(o_serial0_priority_bit))
    else $error("serial0 bit not read back");

  AST_RD_T1: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_rd_sel |=> o_sfr_rdata[IPSEL_BIT_T1] == $past(o_timer1_priority_bit))
    else $error("timer1 bit not read back");

  AST_RD_X1: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_rd_sel |=> o_sfr_rdata[IPSEL_BIT_X1] == $past(o_ext_irq1_priority_bit))
    else $error("ext1 bit not read back");

  AST_RD_T0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_rd_sel |=> o_sfr_rdata[IPSEL_BIT_T0] == $past(o_timer0_priority_bit))
    else $error("timer0 bit not read back");

  AST_RD_X0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ast_rd_sel |=> o_sfr_rdata[IPSEL_BIT_X0] == $past(o_ext_irq0_priority_bit))
    else $error("ext0 bit not read back");

  AST_SPLIT: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ((o_prio_req.hi | o_prio_req.lo) == i_irq_pend)
    && ((o_prio_req.hi & o_prio_req.lo) == 6'h00)
    && (o_hi_pending == (o_prio_req.hi != 6'h00)))
    else $error("priority split wrong");

  AST_REQ_T2: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (o_prio_req.hi[IPSEL_BIT_T2] == (i_irq_pend[IPSEL_BIT_T2] && o_timer2_priority_bit))
    && (o_prio_req.lo[IPSEL_BIT_T2] == (i_irq_pend[IPSEL_BIT_T2] && !o_timer2_priority_bit)))
    else $error("timer2 request on wrong level");

  AST_REQ_S0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (o_prio_req.hi[IPSEL_BIT_S0] == (i_irq_pend[IPSEL_BIT_S0] && o_serial0_priority_bit))
    && (o_prio_req.lo[IPSEL_BIT_S0] == (i_irq_pend[IPSEL_BIT_S0] && !o_serial0_priority_bit)))
    else $error("serial0 request on wrong level");

  AST_REQ_T1: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (o_prio_req.hi[IPSEL_BIT_T1] == (i_irq_pend[IPSEL_BIT_T1] && o_timer1_priority_bit))
    && (o_prio_req.lo[IPSEL_BIT_T1] == (i_irq_pend[IPSEL_BIT_T1] && !o_timer1_priority_bit)))
    else $error("timer1 request on wrong level");

  AST_REQ_X1: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (o_prio_req.hi[IPSEL_BIT_X1] == (i_irq_pend[IPSEL_BIT_X1] && o_ext_irq1_priority_bit))
    && (o_prio_req.lo[IPSEL_BIT_X1] == (i_irq_pend[IPSEL_BIT_X1] && !o_ext_irq1_priority_bit)))
    else $error("ext1 request on wrong level");

  AST_REQ_T0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (o_prio_req.hi[IPSEL_BIT_T0] == (i_irq_pend[IPSEL_BIT_T0] && o_timer0_priority_bit))
    && (o_prio_req.lo[IPSEL_BIT_T0] == (i_irq_pend[IPSEL_BIT_T0] && !o_timer0_priority_bit)))
    else $error("timer0 request on wrong level");

  AST_REQ_X0: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (o_prio_req.hi[IPSEL_BIT_X0] == (i_irq_pend[IPSEL_BIT_X0] && o_ext_irq0_priority_bit))
    && (o_prio_req.lo[IPSEL_BIT_X0] == (i_irq_pend[IPSEL_BIT_X0] && !o_ext_irq0_priority_bit)))
    else $error("ext0 request on wrong level");
endmodule
`default_nettype wire

// *** ipsel_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipsel_core_model (
  input  wire ipsel_pkg::ipsel_prio_req_s i_req,
  output logic [5:0]                      o_grant
);
  import ipsel_pkg::*;
  // high level wins outright, so a low routine can be preempted
  always_comb begin
    o_grant = 6'h00;
    for (int i = 5; i >= 0; i--) if (i_req.lo[i]) o_grant = 6'h01 << i;
    for (int i = 5; i >= 0; i--) if (i_req.hi[i]) o_grant = 6'h01 << i;
  end
endmodule
`default_nettype wire

// *** ipsel_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipsel_top_tb;
  import ipsel_pkg::*;
  logic clk = 0, rst = 1, hit, hip;
  ipsel_sfr_req_s special_function_register = '0;
  ipsel_prio_req_s preq;
  logic [5:0] pend = '0, grant;
  wire logic [5:0] prio;
  logic [7:0] rdata, q[$];
  logic [31:0] seed = 32'h3545c42a, w;
  int mismatches = 0, samples_checked = 0;
  ipsel_top u_ipsel_top (.i_core_clk(clk), .i_sys_rst(rst), .i_sfr(special_function_register), .i_irq_pend(pend),
    .o_sfr_rdata(rdata), .o_sfr_hit(hit), .o_timer2_priority_bit(prio[5]),
    .o_serial0_priority_bit(prio[4]), .o_timer1_priority_bit(prio[3]),
    .o_ext_irq1_priority_bit(prio[2]), .o_timer0_priority_bit(prio[1]),
    .o_ext_irq0_priority_bit(prio[0]), .o_prio_req(preq), .o_hi_pending(hip));
  ipsel_core_model u_ipsel_core_model (.i_req(preq), .o_grant(grant));
  initial forever #2.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_prio(logic [5:0] got, logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t priority bits %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_req(logic [5:0] got, logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t request split %h expected %h", $time, got, exp);
    end
  endtask
  // both raises read with the write in one cycle, so the read must return the old value
  task automatic acc(logic wr, logic [7:0] a, logic [7:0] d, logic both = 1'b0);
    @(negedge clk);
    special_function_register <= '{wr, !wr || both, a, d};
    @(negedge clk);
    special_function_register <= '0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // read data is matched against the oldest queued read
  always @(negedge clk) if (hit === 1'b1) chk(rdata, q.pop_front());
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst <= 0;
    q.push_back(IPSEL_PRIO_RESET);
    acc(0, IPSEL_PRIO_ADDR, 0);
    chk_prio(prio, IPSEL_PRIO_RESET[5:0]);
    $display("test reset value done");
    for (int i = 0; i < 8; i++) begin
      w = rnd();
      pend <= w[29:24];
      acc(1, IPSEL_PRIO_ADDR, w[7:0]);
      acc(1, 8'hb9, ~w[7:0]);
      q.push_back({2'b11, w[5:0]});
      acc(0, IPSEL_PRIO_ADDR, 0);
      chk_prio(prio, w[5:0]);
      chk_req(preq.hi, w[29:24] & w[5:0]);
      chk_req(preq.lo, w[29:24] & ~w[5:0]);
      chk_req(hip, |(w[29:24] & w[5:0]));
      chk_req(|(grant & w[29:24] & w[5:0]), |(w[29:24] & w[5:0]));
      chk_req(|grant, |w[29:24]);
      $display("test %0d done", i);
    end
    q.push_back({2'b11, w[5:0]});
    w = rnd();
    acc(1, IPSEL_PRIO_ADDR, w[7:0], 1'b1);
    chk_prio(prio, w[5:0]);
    $display("test write with read done");
    rst <= 1;
    repeat (2) @(negedge clk);
    rst <= 0;
    q.push_back(IPSEL_PRIO_RESET);
    acc(0, IPSEL_PRIO_ADDR, 0);
    chk_prio(prio, IPSEL_PRIO_RESET[5:0]);
    $display("test mid-run reset done");
    acc(0, 8'hb9, 0);
    chk(8'(q.size()), 8'h00);
    $display("test other address done");
    final_report();
  end
endmodule
`default_nettype wire
